// ===== hw/ssp_clkdiv.sv
// Programmable divider giving a one-cycle enable pulse every div_i+1 cycles.
// Assumes clr_i is asserted whenever the consumer restarts its timing.
`timescale 1ns/1ns
`default_nettype none
module ssp_clkdiv #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic run_i,
  input wire logic clr_i,
  input wire logic [W-1:0] div_i,
  output logic tick_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } ssp_div_t;

  ssp_div_t q;
  ssp_div_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (clr_i) begin
      d.cnt = '0;
    end else if (run_i) begin
      if (q.cnt >= div_i) begin
        d.cnt = '0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;

endmodule
`default_nettype wire

// ===== hw/ssp_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the pins are unrelated to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module ssp_pin_sync #(
  parameter int W = 3
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ssp_sync_t;

  ssp_sync_t q;
  ssp_sync_t d;

  // A change is taken only once the second and third stages agree.
  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_o = q.lvl;

endmodule
`default_nettype wire

// ===== hw/ssp_pkg.sv
// Constants, field positions and types of the synchronous serial port.
// Assumes a 32-bit APB register bus with 8-bit registers in the low byte lane.
package ssp_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BUFFER = 8'h00;
  localparam logic [7:0] ADDR_CTL_ONE = 8'h04;
  localparam logic [7:0] ADDR_CTL_TWO = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_RELOAD = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_POWER = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C1_WCOL = 7;
  localparam int C1_OVF = 6;
  localparam int C1_EN = 5;
  localparam int C1_CKP = 4;
  localparam int C2_GCALL = 7;
  localparam int C2_STOP = 2;
  localparam int C2_START = 0;
  localparam int ST_SMP = 7;
  localparam int ST_CKE = 6;
  localparam int ST_DA = 5;
  localparam int ST_P = 4;
  localparam int ST_S = 3;
  localparam int ST_RW = 2;
  localparam int ST_UA = 1;
  localparam int ST_BF = 0;
  localparam int EV_DONE = 0;
  localparam int EV_START = 1;
  localparam int EV_STOP = 2;
  localparam int EV_WCOL = 3;
  localparam int EV_OVF = 4;
  localparam int EV_W = 5;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [EV_W-1:0] RST_EV = 5'h00;
  localparam logic [7:0] STATUS_WR_MASK = 8'hC0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  // Half bit periods in ref_clk cycles, minus one: full bit of 4, 16, 64.
  localparam logic [7:0] HALF_DIV4 = 8'h01;
  localparam logic [7:0] HALF_DIV16 = 8'h07;
  localparam logic [7:0] HALF_DIV64 = 8'h1F;
  localparam logic [4:0] TEN_BIT_HEAD = 5'h1E;

  typedef enum logic [3:0] {
    SSP_SPI_MST_4 = 4'h0,
    SSP_SPI_MST_16 = 4'h1,
    SSP_SPI_MST_64 = 4'h2,
    SSP_SPI_MST_BRG = 4'h3,
    SSP_SPI_SLV_SS = 4'h4,
    SSP_SPI_SLV = 4'h5,
    SSP_I2C_SLV7 = 4'h6,
    SSP_I2C_SLV10 = 4'h7,
    SSP_I2C_MST = 4'h8
  } ssp_mode_t;

  typedef enum logic [1:0] {
    SSP_MI_IDLE = 2'h0,
    SSP_MI_START = 2'h1,
    SSP_MI_STOP_A = 2'h2,
    SSP_MI_STOP_B = 2'h3
  } ssp_mst_i2c_t;

  typedef enum logic [2:0] {
    SSP_R_BUF = 3'h0,
    SSP_R_C1 = 3'h1,
    SSP_R_C2 = 3'h2,
    SSP_R_ST = 3'h3,
    SSP_R_RLD = 3'h4,
    SSP_R_IST = 3'h5,
    SSP_R_IMSK = 3'h6,
    SSP_R_PWR = 3'h7
  } ssp_reg_t;

endpackage

// ===== hw/ssp_top.sv
// Synchronous serial port: SPI master/slave and I2C slave/master with APB registers.
// Assumes pins arrive asynchronously; sleep_i comes from power logic on ref_clk.
//
// Functional notes
// - Master bit rate is derived from whatever ref_clk is supplied.
// - Idle clock must come from primary, 32.768 kHz secondary or internal RC.
// - Enabled port interrupt wakes the device after a finished master transfer.
// - In sleep the master freezes mid-transfer and resumes on wake.
// - Slave shifts on external clock edges; eight bits set the flag, wake.
// - Any reset disables the port and aborts the transfer.
// - Mode 0,0: ckp0 cke1; 0,1: ckp0 cke0; 1,0: ckp1 cke1; 1,1: ckp1 cke0.
// - A sample point bit selects where input data is captured, in master mode with cke set only.
// - I2C master and slave with general call; start and stop interrupts.
// - I2C meets standard mode and accepts 7-bit and 10-bit addressing.
// - Control registers fully read/write; status low six bits read-only.
// - Control two bits 5 to 2 differ between master and slave mode.
// - Address register is own address in slave, baud reload in master.
// - Completed received byte moves to the buffer and sets the flag.
// - Buffer write loads buffer and shifter at once, no transmit buffering.
// - Shifter is not addressable; software reaches it through the buffer.
// - SPI data shifts most significant bit first.
// - Enable bit 5 of control one; clearing it resets port, bit count.
`timescale 1ns/1ns
`default_nettype none
module ssp_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_i,
  input wire logic [1:0] clk_src_i,
  input wire logic sck_scl_i,
  output logic sck_scl_o,
  output logic sck_scl_oe,
  input wire logic sdi_sda_i,
  output logic sdi_sda_o,
  output logic sdi_sda_oe,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic ss_n_i,
  output logic irq_o,
  output logic wake_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] serial_buffer;
    logic [7:0] serial_shifter;
    logic [7:0] ctl_one;
    logic [7:0] ctl_two;
    logic [7:0] status;
    logic [7:0] reload;
    logic [ssp_pkg::EV_W-1:0] irq_st;
    logic [ssp_pkg::EV_W-1:0] irq_mask;
    logic [3:0] bit_cnt;
    logic busy;
    logic phase;
    logic sck;
    logic sdo;
    logic sda_low;
    logic scl_low;
    logic sck_prev;
    logic sda_prev;
    logic addressed;
    logic first_byte;
    logic ack_pend;
    ssp_pkg::ssp_mst_i2c_t mi;
    logic [31:0] rdata;
    logic err;
  } ssp_state_t;

  ssp_state_t q;
  ssp_state_t d;

  logic [2:0] pins_f;
  logic sck_f;
  logic sda_f;
  logic ss_n_f;
  logic tick;
  logic div_run;
  logic div_clr;
  logic [7:0] div_half;

  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    logic [3:0] r;
    r = {1'b1, 3'h0};
    unique case (a)
      ssp_pkg::ADDR_BUFFER: r = {1'b0, ssp_pkg::SSP_R_BUF};
      ssp_pkg::ADDR_CTL_ONE: r = {1'b0, ssp_pkg::SSP_R_C1};
      ssp_pkg::ADDR_CTL_TWO: r = {1'b0, ssp_pkg::SSP_R_C2};
      ssp_pkg::ADDR_STATUS: r = {1'b0, ssp_pkg::SSP_R_ST};
      ssp_pkg::ADDR_RELOAD: r = {1'b0, ssp_pkg::SSP_R_RLD};
      ssp_pkg::ADDR_IRQ_STATUS: r = {1'b0, ssp_pkg::SSP_R_IST};
      ssp_pkg::ADDR_IRQ_MASK: r = {1'b0, ssp_pkg::SSP_R_IMSK};
      ssp_pkg::ADDR_POWER: r = {1'b0, ssp_pkg::SSP_R_PWR};
      default: r = {1'b1, 3'h0};
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and bit-rate divider
  // ----------------------------------------------------------------
  ssp_pin_sync #(.W(3)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin_i({ss_n_i, sdi_sda_i, sck_scl_i}),
    .level_o(pins_f)
  );

  assign sck_f = pins_f[0];
  assign sda_f = pins_f[1];
  assign ss_n_f = pins_f[2];

  ssp_clkdiv #(.W(8)) u_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .run_i(div_run),
    .clr_i(div_clr),
    .div_i(div_half),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  ssp_pkg::ssp_mode_t mode;
  logic en;
  logic clock_polarity;
  logic cke;
  logic sample_point_select;
  logic spi_mst;
  logic spi_slv;
  logic i2c;
  logic slv_sel;
  logic samp;
  logic shft;
  logic done;
  logic [7:0] sh_next;
  logic [7:0] byte_in;
  logic [ssp_pkg::EV_W-1:0] ev;
  logic [3:0] sel;
  logic acc;
  logic wr;
  logic rd;
  logic lead;
  logic trail;
  logic scl_rise;
  logic scl_fall;
  logic addr_hit;
  logic gcall;

  always_comb begin
    mode = ssp_pkg::ssp_mode_t'(q.ctl_one[3:0]);
    en = q.ctl_one[ssp_pkg::C1_EN];
    clock_polarity = q.ctl_one[ssp_pkg::C1_CKP];
    cke = q.status[ssp_pkg::ST_CKE];
    sample_point_select = q.status[ssp_pkg::ST_SMP];
    spi_mst = 1'b0;
    spi_slv = 1'b0;
    i2c = 1'b0;
    div_half = {1'b0, q.reload[6:0]};
    unique case (mode)
      ssp_pkg::SSP_SPI_MST_4: begin
        spi_mst = 1'b1;
        div_half = ssp_pkg::HALF_DIV4;
      end
      ssp_pkg::SSP_SPI_MST_16: begin
        spi_mst = 1'b1;
        div_half = ssp_pkg::HALF_DIV16;
      end
      ssp_pkg::SSP_SPI_MST_64: begin
        spi_mst = 1'b1;
        div_half = ssp_pkg::HALF_DIV64;
      end
      ssp_pkg::SSP_SPI_MST_BRG: spi_mst = 1'b1;
      ssp_pkg::SSP_SPI_SLV_SS, ssp_pkg::SSP_SPI_SLV: spi_slv = 1'b1;
      ssp_pkg::SSP_I2C_SLV7, ssp_pkg::SSP_I2C_SLV10, ssp_pkg::SSP_I2C_MST: i2c = 1'b1;
      default: spi_slv = 1'b0;
    endcase
    slv_sel = spi_slv && (mode == ssp_pkg::SSP_SPI_SLV || !ss_n_f);
    d = q;
    ev = '0;
    samp = 1'b0;
    shft = 1'b0;
    done = 1'b0;
    addr_hit = 1'b0;
    gcall = 1'b0;
    // Divider stops in sleep so a master transfer freezes in place.
    div_run = en && !sleep_i && (q.busy || q.mi != ssp_pkg::SSP_MI_IDLE ||
      (mode == ssp_pkg::SSP_I2C_MST && (q.ctl_two[ssp_pkg::C2_START] ||
      q.ctl_two[ssp_pkg::C2_STOP])));
    div_clr = !en;
    lead = (sck_f != q.sck_prev) && (sck_f != clock_polarity);
    trail = (sck_f != q.sck_prev) && (sck_f == clock_polarity);
    scl_rise = sck_f && !q.sck_prev;
    scl_fall = !sck_f && q.sck_prev;
    d.sck_prev = sck_f;
    d.sda_prev = sda_f;

    // SPI master timing: first half leaves idle level, second returns.
    // A tick that lands in the first sleep cycle is dropped, not acted on.
    if (en && spi_mst && q.busy && tick && !sleep_i) begin
      if (!q.phase) begin
        d.sck = ~clock_polarity;
        d.phase = 1'b1;
        samp = !sample_point_select && cke;
        shft = !cke;
      end else begin
        d.sck = clock_polarity;
        d.phase = 1'b0;
        samp = sample_point_select || !cke;
        shft = cke && (q.bit_cnt != ssp_pkg::BITS_PER_BYTE - 4'h1);
        d.bit_cnt = q.bit_cnt + 4'h1;
        done = (q.bit_cnt == ssp_pkg::BITS_PER_BYTE - 4'h1);
      end
    end

    // SPI slave runs only from edges of the external clock.
    if (en && slv_sel) begin
      samp = cke ? lead : trail;
      shft = cke ? trail : lead;
      if (samp) begin
        d.bit_cnt = q.bit_cnt + 4'h1;
        done = (q.bit_cnt == ssp_pkg::BITS_PER_BYTE - 4'h1);
      end
    end
    if (spi_slv && mode == ssp_pkg::SSP_SPI_SLV_SS && ss_n_f) begin
      d.bit_cnt = 4'h0;
    end

    sh_next = samp ? {q.serial_shifter[6:0], sda_f} : q.serial_shifter;
    if (!i2c) begin
      d.serial_shifter = sh_next;
      if (shft) begin
        d.sdo = samp ? q.serial_shifter[6] : q.serial_shifter[7];
      end
    end
    byte_in = sh_next;

    // I2C bus conditions and slave addressing.
    if (en && i2c) begin
      if (sck_f && q.sck_prev && q.sda_prev && !sda_f) begin
        d.status[ssp_pkg::ST_S] = 1'b1;
        d.status[ssp_pkg::ST_P] = 1'b0;
        d.first_byte = 1'b1;
        d.addressed = 1'b0;
        d.bit_cnt = 4'h0;
        ev[ssp_pkg::EV_START] = 1'b1;
      end else if (sck_f && q.sck_prev && !q.sda_prev && sda_f) begin
        d.status[ssp_pkg::ST_P] = 1'b1;
        d.status[ssp_pkg::ST_S] = 1'b0;
        d.addressed = 1'b0;
        d.bit_cnt = 4'h0;
        if (mode != ssp_pkg::SSP_I2C_MST) begin
          d.sda_low = 1'b0;
        end
        ev[ssp_pkg::EV_STOP] = 1'b1;
      end else if (mode != ssp_pkg::SSP_I2C_MST && scl_rise &&
                   q.bit_cnt < ssp_pkg::BITS_PER_BYTE) begin
        byte_in = {q.serial_shifter[6:0], sda_f};
        d.serial_shifter = byte_in;
        d.bit_cnt = q.bit_cnt + 4'h1;
        if (q.bit_cnt == ssp_pkg::BITS_PER_BYTE - 4'h1) begin
          if (q.first_byte) begin
            gcall = (byte_in == 8'h00) && q.ctl_two[ssp_pkg::C2_GCALL];
            if (mode == ssp_pkg::SSP_I2C_SLV7) begin
              // Slave mode: control two bits 5:2 mask address bits 4:1.
              addr_hit = (((byte_in[7:1] ^ q.reload[7:1]) &
                ~{3'h0, q.ctl_two[5:2]}) == 7'h00);
            end else begin
              addr_hit = (byte_in[7:3] == ssp_pkg::TEN_BIT_HEAD) &&
                (byte_in[2:1] == q.reload[2:1]);
              d.status[ssp_pkg::ST_UA] = addr_hit;
            end
            d.first_byte = 1'b0;
            if (addr_hit || gcall) begin
              d.addressed = 1'b1;
              d.ack_pend = 1'b1;
              d.status[ssp_pkg::ST_DA] = 1'b0;
              d.status[ssp_pkg::ST_RW] = byte_in[0];
              done = 1'b1;
            end
          end else if (q.addressed) begin
            d.ack_pend = 1'b1;
            d.status[ssp_pkg::ST_DA] = 1'b1;
            done = 1'b1;
          end
        end
      end else if (mode != ssp_pkg::SSP_I2C_MST && scl_fall) begin
        if (q.bit_cnt == ssp_pkg::BITS_PER_BYTE) begin
          d.sda_low = q.ack_pend && !q.status[ssp_pkg::ST_BF];
          d.ack_pend = 1'b0;
          d.bit_cnt = ssp_pkg::ACK_SLOT;
        end else if (q.bit_cnt == ssp_pkg::ACK_SLOT) begin
          d.sda_low = 1'b0;
          d.bit_cnt = 4'h0;
        end
      end
    end

    // I2C master: bits 0 and 2 of control two request start and stop.
    if (en && mode == ssp_pkg::SSP_I2C_MST && tick && !sleep_i) begin
      unique case (q.mi)
        ssp_pkg::SSP_MI_IDLE: begin
          if (q.ctl_two[ssp_pkg::C2_START]) begin
            d.sda_low = 1'b1;
            d.mi = ssp_pkg::SSP_MI_START;
          end else if (q.ctl_two[ssp_pkg::C2_STOP]) begin
            d.sda_low = 1'b1;
            d.mi = ssp_pkg::SSP_MI_STOP_A;
          end
        end
        ssp_pkg::SSP_MI_START: begin
          d.scl_low = 1'b1;
          d.ctl_two[ssp_pkg::C2_START] = 1'b0;
          d.mi = ssp_pkg::SSP_MI_IDLE;
        end
        ssp_pkg::SSP_MI_STOP_A: begin
          d.scl_low = 1'b0;
          d.mi = ssp_pkg::SSP_MI_STOP_B;
        end
        ssp_pkg::SSP_MI_STOP_B: begin
          d.sda_low = 1'b0;
          d.ctl_two[ssp_pkg::C2_STOP] = 1'b0;
          d.mi = ssp_pkg::SSP_MI_IDLE;
        end
      endcase
    end

    // A full byte lands in the buffer unless the last one is unread.
    if (done) begin
      d.busy = 1'b0;
      ev[ssp_pkg::EV_DONE] = 1'b1;
      if (q.status[ssp_pkg::ST_BF]) begin
        ev[ssp_pkg::EV_OVF] = 1'b1;
      end else begin
        d.serial_buffer = byte_in;
        d.status[ssp_pkg::ST_BF] = 1'b1;
      end
      if (!i2c) begin
        d.bit_cnt = 4'h0;
      end
    end

    // ----------------------------------------------------------------
    // APB slave: zero wait states, read data sampled in the setup cycle
    // ----------------------------------------------------------------
    sel = reg_sel(paddr);
    acc = psel && penable;
    wr = acc && pwrite && pstrb[0] && !sel[3];
    rd = acc && !pwrite && !sel[3];
    if (psel && !penable) begin
      d.err = sel[3];
      d.rdata = 32'h0000_0000;
      unique case (ssp_pkg::ssp_reg_t'(sel[2:0]))
        ssp_pkg::SSP_R_BUF: d.rdata[7:0] = q.serial_buffer;
        ssp_pkg::SSP_R_C1: d.rdata[7:0] = q.ctl_one;
        ssp_pkg::SSP_R_C2: d.rdata[7:0] = q.ctl_two;
        ssp_pkg::SSP_R_ST: d.rdata[7:0] = q.status;
        ssp_pkg::SSP_R_RLD: d.rdata[7:0] = q.reload;
        ssp_pkg::SSP_R_IST: d.rdata[ssp_pkg::EV_W-1:0] = q.irq_st;
        ssp_pkg::SSP_R_IMSK: d.rdata[ssp_pkg::EV_W-1:0] = q.irq_mask;
        ssp_pkg::SSP_R_PWR: d.rdata[2:0] = {clk_src_i, sleep_i};
      endcase
    end
    if (rd && ssp_pkg::ssp_reg_t'(sel[2:0]) == ssp_pkg::SSP_R_BUF && !done) begin
      d.status[ssp_pkg::ST_BF] = 1'b0;
    end
    if (wr) begin
      unique case (ssp_pkg::ssp_reg_t'(sel[2:0]))
        ssp_pkg::SSP_R_BUF: begin
          if (q.busy || (spi_slv && q.bit_cnt != 4'h0)) begin
            ev[ssp_pkg::EV_WCOL] = 1'b1;
          end else begin
            d.serial_buffer = pwdata[7:0];
            d.serial_shifter = pwdata[7:0];
            d.sdo = pwdata[7];
            if (en && spi_mst) begin
              d.busy = 1'b1;
              d.phase = 1'b0;
              d.bit_cnt = 4'h0;
            end
          end
        end
        ssp_pkg::SSP_R_C1: d.ctl_one = pwdata[7:0];
        ssp_pkg::SSP_R_C2: d.ctl_two = pwdata[7:0];
        ssp_pkg::SSP_R_ST: begin
          d.status = (d.status & ~ssp_pkg::STATUS_WR_MASK) |
            (pwdata[7:0] & ssp_pkg::STATUS_WR_MASK);
        end
        ssp_pkg::SSP_R_RLD: d.reload = pwdata[7:0];
        ssp_pkg::SSP_R_IST: d.irq_st = q.irq_st & ~pwdata[ssp_pkg::EV_W-1:0];
        ssp_pkg::SSP_R_IMSK: d.irq_mask = pwdata[ssp_pkg::EV_W-1:0];
        ssp_pkg::SSP_R_PWR: d.irq_mask = d.irq_mask;
      endcase
    end

    // Hardware-set flags win over a software clear in the same cycle.
    d.irq_st = d.irq_st | ev;
    d.ctl_one[ssp_pkg::C1_WCOL] = d.ctl_one[ssp_pkg::C1_WCOL] | ev[ssp_pkg::EV_WCOL];
    d.ctl_one[ssp_pkg::C1_OVF] = d.ctl_one[ssp_pkg::C1_OVF] | ev[ssp_pkg::EV_OVF];

    // Disabling the port throws away any transfer and the bit count.
    if (!d.ctl_one[ssp_pkg::C1_EN]) begin
      d.busy = 1'b0;
      d.phase = 1'b0;
      d.bit_cnt = 4'h0;
      d.sda_low = 1'b0;
      d.scl_low = 1'b0;
      d.addressed = 1'b0;
      d.ack_pend = 1'b0;
      d.mi = ssp_pkg::SSP_MI_IDLE;
    end
    // SCK rests at the polarity level between bytes, so that a polarity change
    // never leaves a missing edge in front of the next transfer.
    if (!d.busy) begin
      d.sck = d.ctl_one[ssp_pkg::C1_CKP];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && q.err;
  assign irq_o = |(q.irq_st & q.irq_mask);
  assign wake_o = irq_o;
  // I2C pins are open-drain: only ever pulled low, relying on input direction.
  assign sck_scl_o = i2c ? 1'b0 : q.sck;
  assign sck_scl_oe = en && (i2c ? q.scl_low : spi_mst);
  assign sdi_sda_o = 1'b0;
  assign sdi_sda_oe = en && i2c && q.sda_low;
  assign sdo_o = q.sdo;
  assign sdo_oe = en && (spi_mst || slv_sel);

endmodule
`default_nettype wire

// ===== testbench/ssp_spi_partner.sv
// Behavioural SPI slave facing the port in master mode.
// Assumes sck idles at ckp before load is pulsed.
`timescale 1ns/1ns
`default_nettype none
module ssp_spi_partner (
  input wire logic sck,
  input wire logic mosi,
  input wire logic clock_polarity,
  input wire logic cke,
  input wire logic load,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sr = 8'h00;
  logic first = 1'b0;
  assign miso = sr[7];
  always @(posedge load) begin
    sr = tx;
    first = 1'b1;
    rx = 8'h00;
  end
  // Sent bits refill inverted, so an idle line never repeats a stale bit.
  always @(sck) begin
    if ((sck != clock_polarity) == cke) begin
      rx = {rx[6:0], mosi};
    end else if (first && !cke) begin
      first = 1'b0;
    end else begin
      sr = {sr[6:0], ~sr[7]};
    end
  end
endmodule
`default_nettype wire

// ===== testbench/ssp_top_properties.sv
// Concurrent checks on the serial port's top-level pins.
// Bound to ssp_top; everything runs on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module ssp_props_chk (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic sleep_i,
  input wire logic [1:0] clk_src_i,
  input wire logic sck_scl_o,
  input wire logic sck_scl_oe,
  input wire logic sdo_oe,
  input wire logic irq_o,
  input wire logic wake_o
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_wake_irq: assert property (wake_o == irq_o)
    else $error("wake differs from irq");
  chk_reset_idle: assert property ($fell(srst) |-> !sdo_oe && !sck_scl_oe && !irq_o)
    else $error("port active after reset");
  chk_sleep_hold: assert property (sleep_i |=> $stable(sck_scl_o))
    else $error("clock moved in sleep");
  chk_unmapped_err: assert property (psel && !penable && paddr > 8'h1C
    ##1 penable |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel && !penable && paddr <= 8'h1C
    && paddr[1:0] == 2'h0 ##1 penable |-> !pslverr)
    else $error("mapped access refused");
  chk_upper_zero: assert property (psel && penable |-> prdata[31:8] == 24'h0)
    else $error("read data above byte");
  chk_power_read: assert property (psel && !penable && !pwrite && paddr == 8'h1C
    ##1 penable |-> prdata[2:0] == {$past(clk_src_i), $past(sleep_i)})
    else $error("power read wrong");
  chk_mask_quiet: assert property (psel && penable && pwrite && pstrb[0]
    && paddr == 8'h18 && pwdata[7:0] == 8'h00 |=> !irq_o)
    else $error("masked irq still high");
endmodule
bind ssp_top ssp_props_chk u_chk (.ref_clk(ref_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pslverr(pslverr), .sleep_i(sleep_i), .clk_src_i(clk_src_i),
  .sck_scl_o(sck_scl_o), .sck_scl_oe(sck_scl_oe), .sdo_oe(sdo_oe), .irq_o(irq_o),
  .wake_o(wake_o));
`default_nettype wire

// ===== testbench/tb_sync_serial_port_spi_i2c.sv
// Self-checking bench: registers over APB and SPI master transfers.
// Assumes the partner model stands in for the external SPI slave.
`timescale 1ns/1ns
`default_nettype none
module tb_sync_serial_port_spi_i2c;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_i = 1'b0, load = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [1:0] clk_src = 2'h0;
  logic pready, pslverr, sck_o, sck_oe, sdo_o, sdo_oe, irq_o, miso, e;
  logic [7:0] r, tx, ptx, prx;
  int err_total = 0, compares = 0, seed = 32'h40df, m = 0, n;
  always #5 ref_clk = ~ref_clk;
  ssp_top u_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_i(sleep_i), .clk_src_i(clk_src),
    .sck_scl_i(1'b1), .sck_scl_o(sck_o), .sck_scl_oe(sck_oe), .sdi_sda_i(miso),
    .sdi_sda_o(), .sdi_sda_oe(), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ss_n_i(1'b1),
    .irq_o(irq_o), .wake_o());
  ssp_spi_partner u_part (.sck(sck_o), .mosi(sdo_o), .clock_polarity(m[1]), .cke(!m[0]),
    .load(load), .tx(ptx), .miso(miso), .rx(prx));
  function automatic logic [7:0] ctl1(input int k);
    return {3'b001, k[1], 4'h1};
  endfunction
  function automatic logic [7:0] st(input int k);
    return {k[1], !k[0], 6'h00};
  endfunction
  task automatic complete_run;
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] x);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      complete_run();
    end
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    clk_src <= 2'($random(seed));
    @(posedge ref_clk);
    apb(0, 8'h04, 0);
    cmp(r, 8'h00);
    apb(0, 8'h20, 0);
    cmp({7'h0, e}, 8'h01);
    apb(0, 8'h1C, 0);
    cmp(r, {5'h0, clk_src, 1'b0});
    apb(1, 8'h0C, 8'hFF);
    apb(0, 8'h0C, 0);
    cmp(r, 8'hC0);
    tx = $random(seed);
    apb(1, 8'h08, tx);
    apb(0, 8'h08, 0);
    cmp(r, tx);
    apb(1, 8'h18, 8'h01);
    for (m = 0; m < 5; m++) begin
      apb(1, 8'h0C, st(m));
      apb(1, 8'h04, ctl1(m));
      ptx = $random(seed);
      tx = $random(seed);
      load <= 1'b1;
      @(posedge ref_clk);
      load <= 1'b0;
      apb(1, 8'h00, tx);
      // A second write while busy must collide, not queue.
      apb(1, 8'h00, ~tx);
      if (m == 4) begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        apb(0, 8'h04, 0);
        cmp(r, 8'h00);
        apb(0, 8'h14, 0);
        cmp(r, 8'h00);
      end else begin
        repeat (20) @(posedge ref_clk);
        sleep_i <= 1'b1;
        repeat (30) @(posedge ref_clk);
        sleep_i <= 1'b0;
        n = 0;
        while (irq_o !== 1'b1 && n < 3000) begin
          @(posedge ref_clk);
          n++;
        end
        if (n >= 3000) begin
          err_total++;
          complete_run();
        end
        cmp(prx, tx);
        cmp({5'h0, sdo_oe, sck_oe, sck_o}, {5'h0, 2'b11, m[1]});
        apb(0, 8'h04, 0);
        cmp(r, ctl1(m) | 8'h80);
        apb(0, 8'h00, 0);
        cmp(r, ptx);
        apb(0, 8'h14, 0);
        cmp(r, 8'h09);
        apb(0, 8'h0C, 0);
        cmp(r, st(m));
        apb(1, 8'h14, 8'h1F);
        apb(1, 8'h04, 8'h00);
        cmp({6'h0, sdo_oe, sck_oe}, 8'h00);
      end
    end
    apb(1, 8'h18, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
